// ### spi_port_map.vh
/*
 Register offsets, field positions, reset values and timing counts of the
 serial configuration port. Assumes it is included by bare name, before the
 design code.
*/
`ifndef SPI_PORT_MAP_VH
`define SPI_PORT_MAP_VH

// ==========================================================
// Clock and timing
`define CLK_MHZ          125
`define SOFT_RST_MS      5
`define SOFT_RST_CYC     (`SOFT_RST_MS * `CLK_MHZ * 1000)
`define TIE_HIGH_US      100
`define TIE_CYC          (`TIE_HIGH_US * `CLK_MHZ)
`define FRAME_GAP_NS     1000
`define FRAME_GAP_CYC    ((`FRAME_GAP_NS * `CLK_MHZ) / 1000)

// ==========================================================
// Register offsets
`define ADDR_CFG_A       15'h0000
`define ADDR_CHAN_SEL    15'h0008
`define ADDR_OUT_FMT     15'h0561
`define ADDR_BUF_CTRL    15'h1A4C

// ==========================================================
// Reset values
`define RST_CHAN_SEL     2'h3
`define RST_OUT_FMT      8'h01
`define RST_BUF_CTRL     8'h00

// ==========================================================
// Field positions
`define CFGA_SOFT_M      7
`define CFGA_LSB_M       6
`define CFGA_ASC_M       5
`define CFGA_ASC         2
`define CFGA_LSB         1
`define CFGA_SOFT        0
`define CHSEL_A          0
`define CHSEL_B          1

`endif

// ### port_sync2.v
/*
 Two-flop synchroniser for a group of unrelated level inputs.
 Assumes each bit is a slow level; bits are not coherent with each other.
*/
`default_nettype none

module port_sync2 #(
   parameter             WIDTH   = 3,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   input  wire             clk_sys_i,
   input  wire             reset_i,
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] meta_r;
   reg [WIDTH-1:0] sync_r;

   // ==========================================================
   // Two stages; the first is read by the second only
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= RST_VAL;
         sync_r <= RST_VAL;
      end else begin
         meta_r <= async_i;
         sync_r <= meta_r;
      end
   end

   assign sync_o = sync_r;

endmodule // port_sync2

`default_nettype wire

// ### chan_regs.v
/*
 Per-channel copies of one local register.
 Assumes the caller decodes the address and supplies the channel mask.
*/
`default_nettype none

module chan_regs #(
   parameter         NUM_CH  = 2,
   parameter         W       = 8,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input  wire                clk_sys_i,
   input  wire                reset_i,
   input  wire                clear_i,
   input  wire                we_i,
   input  wire [NUM_CH-1:0]   sel_i,
   input  wire [W-1:0]        wdata_i,
   output wire [NUM_CH*W-1:0] q_o
);

   genvar ch;

   // ==========================================================
   // One copy per channel, each written when its select bit is set
   generate
      for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_copy
         reg [W-1:0] val_r;
         always @(posedge clk_sys_i or posedge reset_i) begin
            if (reset_i) begin
               val_r <= RST_VAL;
            end else if (clear_i) begin
               val_r <= RST_VAL;
            end else if (we_i && sel_i[ch]) begin
               val_r <= wdata_i;
            end
         end
         assign q_o[ch*W +: W] = val_r;
      end
   endgenerate

endmodule // chan_regs

`default_nettype wire

// ### spi_config_port.v
/*
 Three-wire serial configuration port with a small register map,
 per-channel local registers and soft reset.
 Assumes serial clock, select and data arrive asynchronously and are
 much slower than clk_sys_i (at least four system clocks per level).
*/
// Operation
// RULE_01: Select fall then clock rise starts frame
// RULE_02: Clock and data ignored while deselected
// RULE_03: Held select streams successive bytes
// RULE_04: Select high between bytes pauses, keeps state; the code ends the frame after 1000 ns high
// RULE_05: Select tied high: pins high-impedance, secondary
// RULE_06: Every phase is whole eight-bit bytes
// RULE_07: First instruction bit chooses read or write; the code takes it from the last bit when LSB-first
// RULE_08: Read turns data pin to output
// RULE_09: Data pin input on write, output readback
// RULE_10: MSB first after reset, LSB optional
// RULE_11: Each register holds exactly eight bits
// RULE_12: Register space in fixed address ranges
// RULE_13: Output sample format resets to 0x01
// RULE_14: Host writes zeros to unassigned bits
// RULE_15: Host never writes fully unassigned addresses
// RULE_16: Reset loads register defaults
// RULE_17: Local registers duplicated per channel
// RULE_18: Channel bits steer local writes, both broadcast
// RULE_19: Both bits set reads channel A
// RULE_20: Global registers ignore channel selection
// RULE_21: Host keeps lines quiet during sampling
// RULE_22: Writing 0x81 soft resets; wait 5 ms
// RULE_23: Mirrored bits select LSB-first order
// RULE_24: Mirrored bits choose address increment/decrement
// RULE_25: Two instruction bytes, then stepping data
// RULE_26: Sample on rise, launch on fall
`include "spi_port_map.vh"
`default_nettype none

module spi_config_port #(
   parameter        NUM_CH       = 2,
   parameter [19:0] SOFT_RST_CYC = `SOFT_RST_CYC,
   parameter [13:0] TIE_CYC      = `TIE_CYC
) (
   input  wire       clk_sys_i,
   input  wire       reset_i,
   input  wire       sclk_i,
   input  wire       port_select_n_i,
   input  wire       sdio_i,
   output wire       sdio_o,
   output wire       sdio_oe_o,
   output wire       secondary_fn_o,
   output wire       frame_active_o,
   output wire       lsb_first_o,
   output wire       addr_ascend_o,
   output wire [1:0] chan_sel_o,
   output wire [7:0] sample_format_o,
   output wire [7:0] buf_ctrl_a_o,
   output wire [7:0] buf_ctrl_b_o,
   output wire       boot_busy_o
);

   // ==========================================================
   // Frame phases
   localparam [1:0] PH_ADDR_HI = 2'b00;
   localparam [1:0] PH_ADDR_LO = 2'b01;
   localparam [1:0] PH_DATA    = 2'b10;

   localparam [13:0] GAP_CYC = `FRAME_GAP_CYC;

   // ==========================================================
   // Declarations
   wire                sclk_s;
   wire                csn_s;
   wire                sdio_s;
   wire [NUM_CH*8-1:0] buf_q;

   reg        sclk_d_r;
   reg [2:0]  bit_cnt_r;
   reg [1:0]  phase_r;
   reg        rd_r;
   reg [14:0] addr_r;
   reg [7:0]  shin_r;
   reg [7:0]  tx_r;
   reg        sdio_r;
   reg        sdio_oe_r;
   reg        launched_r;
   reg        frame_live_r;
   reg [13:0] hi_cnt_r;
   reg        secondary_r;
   reg        cfg_lsb_r;
   reg        cfg_asc_r;
   reg [1:0]  chsel_r;
   reg [7:0]  fmt_r;
   reg        soft_rst_r;
   reg [19:0] boot_cnt_r;
   reg        busy_r;
   reg [7:0]  rd_data;

   // ==========================================================
   // Bit at the head of a byte for the current order
   function tx_head;
      input [7:0] v;
      input       lsb;
      begin
         tx_head = lsb ? v[0] : v[7];
      end
   endfunction

   // Shift one bit out of a byte in the current order
   function [7:0] tx_shift;
      input [7:0] v;
      input       lsb;
      begin
         tx_shift = lsb ? {1'b0, v[7:1]} : {v[6:0], 1'b0};
      end
   endfunction

   // ==========================================================
   // Pin synchronisers; select resets deasserted
   port_sync2 #(
      .WIDTH   (3),
      .RST_VAL (3'b010)
   ) u_sync (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .async_i   ({sclk_i, port_select_n_i, sdio_i}),
      .sync_o    ({sclk_s, csn_s, sdio_s})
   );

   // ==========================================================
   // Edge detection and frame qualifiers
   // RULE_02: deselect gates clock
   wire cs_act    = ~csn_s & ~secondary_r;
   wire sclk_rise = sclk_s & ~sclk_d_r;
   wire sclk_fall = ~sclk_s & sclk_d_r;
   wire shift_en  = cs_act & sclk_rise;
   // RULE_10: order of input
   wire [7:0] sh_new = cfg_lsb_r ? {sdio_s, shin_r[7:1]} : {shin_r[6:0], sdio_s};
   // RULE_06: whole byte boundary
   wire byte_done = shift_en & (bit_cnt_r == 3'h7);
   // RULE_24: address step
   wire [14:0] addr_step = cfg_asc_r ? (addr_r + 15'h0001) : (addr_r - 15'h0001);
   wire [14:0] rd_addr   = (phase_r == PH_ADDR_LO) ? {addr_r[14:8], sh_new} : addr_step;
   wire wr_stb    = byte_done & (phase_r == PH_DATA) & ~rd_r;
   wire frame_gap = (hi_cnt_r == GAP_CYC);
   wire rd_phase  = (phase_r == PH_DATA) & rd_r;

   // ==========================================================
   // Serial clock history
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         sclk_d_r <= 1'b0;
      end else begin
         sclk_d_r <= sclk_s;
      end
   end

   // ==========================================================
   // Select-high counter: frame end and tied-high detection
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         hi_cnt_r    <= 14'h0000;
         secondary_r <= 1'b0;
      end else if (~csn_s) begin
         hi_cnt_r    <= 14'h0000;
         secondary_r <= 1'b0;
      end else begin
         if (hi_cnt_r != TIE_CYC) begin
            hi_cnt_r <= hi_cnt_r + 14'h0001;
         end
         // RULE_05: tied high detect
         if (hi_cnt_r == TIE_CYC) begin
            secondary_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Receive sequencer: instruction, address and data bytes
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         bit_cnt_r    <= 3'h0;
         phase_r      <= PH_ADDR_HI;
         rd_r         <= 1'b0;
         addr_r       <= 15'h0000;
         shin_r       <= 8'h00;
         frame_live_r <= 1'b0;
      end else if (soft_rst_r || frame_gap) begin
         // RULE_04: short stall keeps state
         bit_cnt_r    <= 3'h0;
         phase_r      <= PH_ADDR_HI;
         rd_r         <= 1'b0;
         shin_r       <= 8'h00;
         frame_live_r <= 1'b0;
      end else if (shift_en) begin
         // RULE_26: sample on rise
         shin_r    <= sh_new;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         // RULE_01: first rise frames
         frame_live_r <= 1'b1;
         if (bit_cnt_r == 3'h7) begin
            case (phase_r)
               PH_ADDR_HI: begin
                  // RULE_07: read or write bit
                  rd_r         <= sh_new[7];
                  addr_r[14:8] <= sh_new[6:0];
                  phase_r      <= PH_ADDR_LO;
               end
               PH_ADDR_LO: begin
                  // RULE_25: address then data
                  addr_r[7:0] <= sh_new;
                  phase_r     <= PH_DATA;
               end
               PH_DATA: begin
                  // RULE_03: streaming next address
                  addr_r <= addr_step;
               end
               default: begin
                  phase_r <= PH_ADDR_HI;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // Readback register selection
   always @* begin
      case (rd_addr)
         `ADDR_CFG_A: begin
            // RULE_23: mirrored order bits
            rd_data = {1'b0, cfg_lsb_r, cfg_asc_r, 2'b00, cfg_asc_r, cfg_lsb_r, 1'b0};
         end
         `ADDR_CHAN_SEL: begin
            rd_data = {6'h00, chsel_r};
         end
         `ADDR_OUT_FMT: begin
            // RULE_20: globals ignore channel
            rd_data = fmt_r;
         end
         `ADDR_BUF_CTRL: begin
            // RULE_19: channel A wins
            if (chsel_r[`CHSEL_A]) begin
               rd_data = buf_q[7:0];
            end else if (chsel_r[`CHSEL_B]) begin
               rd_data = buf_q[15:8];
            end else begin
               rd_data = 8'h00;
            end
         end
         default: begin
            rd_data = 8'h00;
         end
      endcase
   end

   // ==========================================================
   // Transmit path: load at byte end, launch on falling edge
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         tx_r       <= 8'h00;
         sdio_r     <= 1'b0;
         launched_r <= 1'b0;
      end else if (soft_rst_r || frame_gap) begin
         tx_r       <= 8'h00;
         sdio_r     <= 1'b0;
         launched_r <= 1'b0;
      end else if (byte_done && (phase_r != PH_ADDR_HI) && rd_r) begin
         tx_r <= rd_data;
      end else if (cs_act && sclk_fall && rd_phase) begin
         // RULE_26: launch on fall
         sdio_r     <= tx_head(tx_r, cfg_lsb_r);
         tx_r       <= tx_shift(tx_r, cfg_lsb_r);
         launched_r <= 1'b1;
      end
   end

   // ==========================================================
   // Data pin direction
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         sdio_oe_r <= 1'b0;
      end else begin
         // RULE_08: turn to output
         // RULE_09: input unless readback
         sdio_oe_r <= cs_act & rd_phase & launched_r & ~soft_rst_r & ~frame_gap;
      end
   end

   // ==========================================================
   // Global registers and soft reset
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         // RULE_16: defaults on reset
         cfg_lsb_r  <= 1'b0;
         cfg_asc_r  <= 1'b0;
         chsel_r    <= `RST_CHAN_SEL;
         // RULE_13: format default
         fmt_r      <= `RST_OUT_FMT;
         soft_rst_r <= 1'b0;
      end else if (soft_rst_r) begin
         cfg_lsb_r  <= 1'b0;
         cfg_asc_r  <= 1'b0;
         chsel_r    <= `RST_CHAN_SEL;
         fmt_r      <= `RST_OUT_FMT;
         soft_rst_r <= 1'b0;
      end else if (wr_stb) begin
         // RULE_12: fixed address decode
         case (addr_r)
            `ADDR_CFG_A: begin
               // RULE_23: either mirror sets order
               cfg_lsb_r  <= sh_new[`CFGA_LSB_M] | sh_new[`CFGA_LSB];
               // RULE_24: either mirror sets direction
               cfg_asc_r  <= sh_new[`CFGA_ASC_M] | sh_new[`CFGA_ASC];
               // RULE_22: self-clearing soft reset
               soft_rst_r <= sh_new[`CFGA_SOFT_M] | sh_new[`CFGA_SOFT];
            end
            `ADDR_CHAN_SEL: begin
               chsel_r <= sh_new[1:0];
            end
            `ADDR_OUT_FMT: begin
               // RULE_11: full eight-bit store
               fmt_r <= sh_new;
            end
            default: begin
               soft_rst_r <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Recovery timer after soft reset
   always @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         boot_cnt_r <= 20'h00000;
         busy_r     <= 1'b0;
      end else if (soft_rst_r) begin
         // RULE_22: recovery window
         boot_cnt_r <= SOFT_RST_CYC;
         busy_r     <= 1'b1;
      end else if (boot_cnt_r != 20'h00000) begin
         boot_cnt_r <= boot_cnt_r - 20'h00001;
         busy_r     <= (boot_cnt_r != 20'h00001);
      end else begin
         busy_r <= 1'b0;
      end
   end

   // ==========================================================
   // Local register copies
   // RULE_17: one copy per channel
   // RULE_18: channel bits steer writes
   chan_regs #(
      .NUM_CH  (NUM_CH),
      .W       (8),
      .RST_VAL (`RST_BUF_CTRL)
   ) u_buf_ctrl (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .clear_i   (soft_rst_r),
      .we_i      (wr_stb && (addr_r == `ADDR_BUF_CTRL)),
      .sel_i     (chsel_r[NUM_CH-1:0]),
      .wdata_i   (sh_new),
      .q_o       (buf_q)
   );

   // ==========================================================
   // Outputs, all from flip-flops
   assign sdio_o          = sdio_r;
   // RULE_05: released when tied high
   assign sdio_oe_o       = sdio_oe_r;
   assign secondary_fn_o  = secondary_r;
   assign frame_active_o  = frame_live_r;
   assign lsb_first_o     = cfg_lsb_r;
   assign addr_ascend_o   = cfg_asc_r;
   assign chan_sel_o      = chsel_r;
   assign sample_format_o = fmt_r;
   assign buf_ctrl_a_o    = buf_q[7:0];
   assign buf_ctrl_b_o    = buf_q[15:8];
   assign boot_busy_o     = busy_r;

endmodule // spi_config_port

`default_nettype wire

// ### spi_port_checker.sv
/*
 Concurrent checks on the serial configuration port, seen from its ports.
 Assumes it is bound into spi_config_port with the same count parameters.
*/
`default_nettype none

module spi_port_checker #(
   parameter [19:0] SOFT_RST_CYC = 20'h00032,
   parameter [13:0] TIE_CYC      = 14'h012C
) (
   input wire logic       clk_sys_i,
   input wire logic       reset_i,
   input wire logic       sclk_i,
   input wire logic       port_select_n_i,
   input wire logic       sdio_o,
   input wire logic       sdio_oe_o,
   input wire logic       secondary_fn_o,
   input wire logic       frame_active_o,
   input wire logic [1:0] chan_sel_o,
   input wire logic [7:0] sample_format_o,
   input wire logic [7:0] buf_ctrl_b_o,
   input wire logic       boot_busy_o
);
   logic [15:0] hi_cnt_r;
   logic [19:0] busy_cnt_r;

   // ==============================
   // Span counters: select high, busy high
   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         hi_cnt_r   <= 16'h0000;
         busy_cnt_r <= 20'h00000;
      end else begin
         hi_cnt_r   <= port_select_n_i ? hi_cnt_r + {15'h0000, ~&hi_cnt_r} : 16'h0000;
         busy_cnt_r <= boot_busy_o ? busy_cnt_r + 20'h00001 : 20'h00000;
      end
   end

   // ==============================
   // Properties
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   property p_oe_drop;
      port_select_n_i [*8] |-> !sdio_oe_o;
   endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("data pin driven while deselected");
   property p_launch;
      $changed(sdio_o) && sdio_oe_o |-> !sclk_i;
   endproperty
   a_launch: assert property (p_launch) else $error("readback bit moved while clock high");
   property p_frame_start;
      $rose(frame_active_o) |-> !port_select_n_i;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame began deselected");
   property p_stall;
      port_select_n_i && hi_cnt_r < 16'h0064 && $past(frame_active_o) |-> frame_active_o;
   endproperty
   a_stall: assert property (p_stall) else $error("short pause lost the frame");
   property p_tie_set;
      hi_cnt_r > 16'(TIE_CYC) + 16'h0008 |-> secondary_fn_o;
   endproperty
   a_tie_set: assert property (p_tie_set) else $error("tied-high mode not entered");
   property p_busy_len;
      $fell(boot_busy_o) |-> busy_cnt_r == SOFT_RST_CYC;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("boot busy span wrong");
   property p_soft_def;
      $rose(boot_busy_o) |-> ##1 (sample_format_o == 8'h01 && chan_sel_o == 2'b11
                                  && buf_ctrl_b_o == 8'h00);
   endproperty
   a_soft_def: assert property (p_soft_def) else $error("soft reset left non-defaults");
   property p_chan_b;
      $changed(buf_ctrl_b_o) |-> $past(chan_sel_o) != 2'b01 or ##[0:1] boot_busy_o;
   endproperty
   a_chan_b: assert property (p_chan_b) else $error("channel B copy written unselected");

   c_read: cover property ($rose(sdio_oe_o));
   c_busy: cover property ($rose(boot_busy_o));
   c_tie: cover property ($rose(secondary_fn_o));
endmodule // spi_port_checker

`default_nettype wire

// ### spi_host_model.sv
/*
 Behavioural serial host: frames, shifts and samples configuration bytes.
 Assumes the bench resolves the data line and calls one task at a time.
*/
`default_nettype none

module spi_host_model (
   output var logic sclk_o,
   output var logic select_n_o,
   output var logic sdio_o,
   input wire logic line_i
);
   timeunit 1ns;
   timeprecision 100ps;

   logic       lsb = 1'b0;
   logic [7:0] buf_q [4];

   initial begin
      sclk_o     = 1'b0;
      select_n_o = 1'b1;
      sdio_o     = 1'b0;
   end

   task automatic shift(input logic [7:0] tx, input logic drv, output logic [7:0] rx);
      int i;
      for (i = 0; i < 8; i++) begin
         sdio_o = drv ? tx[lsb ? i : 7 - i] : ~sdio_o;
         #40 sclk_o = 1'b1;
         rx[lsb ? i : 7 - i] = line_i;
         #40 sclk_o = 1'b0;
      end
   endtask

   task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic stall);
      logic [7:0] rx;
      int         k;
      select_n_o = 1'b0;
      #40;
      shift({rd, a[14:8]}, 1'b1, rx);
      shift(a[7:0], 1'b1, rx);
      for (k = 0; k < n; k++) begin
         if (stall && k > 0) begin
            #40 select_n_o = 1'b1;  // Last fall launches next first bit
            #400 select_n_o = 1'b0;
            #40;
         end
         shift(buf_q[k], !rd, rx);
         buf_q[k] = rx;
      end
      #40 select_n_o = 1'b1;
      #1200;
   endtask

   // clock and data wiggle while deselected
   task automatic noise();
      int i;
      for (i = 0; i < 12; i++) begin
         sdio_o = ~sdio_o;
         #40 sclk_o = ~sclk_o;
      end
   endtask
endmodule // spi_host_model

`default_nettype wire

// ### spi_config_port_channel_paging_bench.sv
/*
 Self-checking bench for the serial configuration port with a host model.
 Assumes the port, the host model and the checker are compiled before it.
*/
`default_nettype none

module spi_config_port_channel_paging_bench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam [19:0] SOFT_CYC = 20'h00032;
   localparam [13:0] TIE_CYC  = 14'h012C;

   logic       clk_sys_i   = 1'b0;
   logic       reset_i     = 1'b1;
   logic       saw_busy    = 1'b0;
   int         errors      = 0;
   int         checks_done = 0;
   wire        sclk, sel_n, host_d, dev_d, dev_oe, line, sec, frm, lsb_f, asc, busy;
   wire [1:0]  chan;
   wire [7:0]  fmt, buf_a, buf_b, flags;

   // Device wins the line only while it drives
   assign line  = dev_oe ? dev_d : host_d;
   assign flags = {busy, sec, frm, dev_oe, lsb_f, asc, chan};

   // 125 MHz system clock
   always #4 clk_sys_i = ~clk_sys_i;

   // Remember that the boot sequence ran
   always @(posedge clk_sys_i) if (busy === 1'b1) saw_busy <= 1'b1;

   spi_config_port #(.SOFT_RST_CYC(SOFT_CYC), .TIE_CYC(TIE_CYC)) spi_config_port_inst (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk), .port_select_n_i(sel_n),
      .sdio_i(line), .sdio_o(dev_d), .sdio_oe_o(dev_oe), .secondary_fn_o(sec),
      .frame_active_o(frm), .lsb_first_o(lsb_f), .addr_ascend_o(asc), .chan_sel_o(chan),
      .sample_format_o(fmt), .buf_ctrl_a_o(buf_a), .buf_ctrl_b_o(buf_b), .boot_busy_o(busy)
   );
   spi_host_model spi_host_model_inst (
      .sclk_o(sclk), .select_n_o(sel_n), .sdio_o(host_d), .line_i(line)
   );

   // ==============================
   // Helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      spi_host_model_inst.buf_q[0] = d;
      spi_host_model_inst.frame(1'b0, a, 1, 1'b0);
   endtask

   task automatic rd(input logic [14:0] a, input int n, input logic stall);
      spi_host_model_inst.frame(1'b1, a, n, stall);
   endtask

   function automatic logic [7:0] rb(input int k);
      return spi_host_model_inst.buf_q[k];
   endfunction

   task automatic give_verdict();
      if (errors == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Cut a hang short
   initial begin
      #400us;
      errors++;
      give_verdict();
   end

   // ==============================
   // Test sequence
   initial begin
      repeat (6) @(posedge clk_sys_i);
      #1 reset_i = 1'b0;
      #24;
      check("flags", flags, 8'h03);
      check("format", fmt, 8'h01);
      check("buf a", buf_a, 8'h00);
      wr(15'h0561, 8'h5A);
      check("format", fmt, 8'h5A);
      rd(15'h0561, 1, 1'b0);
      check("format rd", rb(0), 8'h5A);
      wr(15'h0008, 8'h01);
      wr(15'h1A4C, 8'h11);
      wr(15'h0008, 8'h02);
      wr(15'h1A4C, 8'h22);
      wr(15'h0561, 8'h7E);
      check("buf a", buf_a, 8'h11);
      check("buf b", buf_b, 8'h22);
      check("format", fmt, 8'h7E);
      rd(15'h1A4C, 1, 1'b0);
      check("buf b rd", rb(0), 8'h22);
      wr(15'h0008, 8'h03);
      wr(15'h1A4C, 8'h33);
      check("buf a", buf_a, 8'h33);
      check("buf b", buf_b, 8'h33);
      wr(15'h0008, 8'h02);
      wr(15'h1A4C, 8'h44);
      wr(15'h0008, 8'h03);
      rd(15'h1A4C, 1, 1'b0);
      check("both rd", rb(0), 8'h33);
      rd(15'h0009, 2, 1'b1);
      check("desc 0", rb(0), 8'h00);
      check("desc 1", rb(1), 8'h03);
      wr(15'h0000, 8'h20);
      check("flags", flags, 8'h07);
      rd(15'h0007, 2, 1'b0);
      check("asc 0", rb(0), 8'h00);
      check("asc 1", rb(1), 8'h03);
      rd(15'h0000, 1, 1'b0);
      check("cfg rd", rb(0), 8'h24);
      wr(15'h0000, 8'h02);
      check("flags", flags, 8'h0B);
      spi_host_model_inst.lsb = 1'b1;
      wr(15'h0561, 8'h0D);
      check("format", fmt, 8'h0D);
      rd(15'h0561, 1, 1'b0);
      check("lsb rd", rb(0), 8'h0D);
      wr(15'h0000, 8'h81);
      spi_host_model_inst.lsb = 1'b0;
      check("busy seen", {7'h00, saw_busy}, 8'h01);
      check("flags", flags, 8'h03);
      check("format", fmt, 8'h01);
      spi_host_model_inst.noise();
      repeat (320) @(posedge clk_sys_i);
      #1;
      check("flags", flags, 8'h43);
      rd(15'h0561, 1, 1'b0);
      check("after noise", rb(0), 8'h01);
      check("flags", flags, 8'h03);
      give_verdict();
   end
endmodule // spi_config_port_channel_paging_bench

bind spi_config_port spi_port_checker #(.SOFT_RST_CYC(SOFT_RST_CYC), .TIE_CYC(TIE_CYC))
   spi_port_checker_inst (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sclk_i(sclk_i),
   .port_select_n_i(port_select_n_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
   .secondary_fn_o(secondary_fn_o), .frame_active_o(frame_active_o),
   .chan_sel_o(chan_sel_o), .sample_format_o(sample_format_o),
   .buf_ctrl_b_o(buf_ctrl_b_o), .boot_busy_o(boot_busy_o));

`default_nettype wire
